/* File: logic/eps_defines.svh */
`ifndef EPS_DEFINES_SVH
`define EPS_DEFINES_SVH

// Register byte offsets on the bus.
`define EPS_OFF_TIMEBASE 8'h00
`define EPS_OFF_SHUTDOWN 8'h04
`define EPS_OFF_RESTART 8'h08
`define EPS_OFF_STEER 8'h0C
`define EPS_OFF_CHCTRL 8'h10

// Reset values.
`define EPS_RST_TIMEBASE 8'h00
`define EPS_RST_SHUTDOWN 8'h00
`define EPS_RST_RESTART 8'h00
`define EPS_RST_STEER 8'h01
`define EPS_RST_CHCTRL 8'h00

// Field positions of the shutdown register.
`define EPS_SD_FLAG 7
`define EPS_SD_SRC_HI 6
`define EPS_SD_SRC_LO 4
`define EPS_SD_AC_HI 3
`define EPS_SD_AC_LO 2
`define EPS_SD_BD_HI 1
`define EPS_SD_BD_LO 0

// Field positions of the restart and delay register.
`define EPS_RS_EN 7
`define EPS_RS_DC_HI 6
`define EPS_RS_DC_LO 0

// Field positions of the steering register.
`define EPS_ST_SYNC 4
`define EPS_ST_EN_HI 3
`define EPS_ST_EN_LO 0

// Field positions of the channel control register.
`define EPS_CC_CFG_HI 7
`define EPS_CC_CFG_LO 6
`define EPS_CC_CSYNC_HI 5
`define EPS_CC_CSYNC_LO 4
`define EPS_CC_MODE_HI 3
`define EPS_CC_MODE_LO 0

// One instruction cycle is four oscillator periods.
`define EPS_OSC_PER_INSTR 3'h4
`define EPS_INSTR_LAST 2'h3

// Mode field upper bits for PWM operation.
`define EPS_MODE_PWM 2'h3

`endif

/* File: logic/eps_pkg.sv */
package eps_pkg;

	// One pin as seen by the bridge stage: level and drive enable.
	typedef struct packed {
		logic o;
		logic oe;
	} eps_pin_type;

	// Output configuration codes.
	typedef enum logic [1:0] {
		EPS_CFG_SINGLE = 2'h0,
		EPS_CFG_FWD = 2'h1,
		EPS_CFG_HALF = 2'h2,
		EPS_CFG_REV = 2'h3
	} eps_config_type;

	// Activation delay states, Gray coded along the path.
	typedef enum logic [1:0] {
		EPS_DLY_IDLE = 2'h0,
		EPS_DLY_WAIT = 2'h1,
		EPS_DLY_ON = 2'h3
	} eps_dly_state_type;

	// State of one activation delay line.
	typedef struct packed {
		eps_dly_state_type state;
		logic [6:0] cnt;
		logic out;
	} eps_dly_reg_type;

	// State of the whole block.
	typedef struct packed {
		logic [7:0] timebase;
		logic ase;
		logic [2:0] src;
		logic [1:0] ac;
		logic [1:0] bd;
		logic rsen;
		logic [6:0] dc;
		logic sync;
		logic [3:0] steer_req;
		logic [3:0] steer_act;
		logic [3:0] mode;
		logic [1:0] csync;
		eps_config_type cfg;
		logic [2:0] in_meta;
		logic [2:0] in_sync;
		logic [1:0] cmp_held;
		logic [1:0] tick_cnt;
		logic wr_pend;
		logic addr_ok;
		logic [7:0] addr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
		logic [3:0] period_tick;
		eps_pin_type [3:0] pins;
	} eps_top_reg_type;

endpackage

/* File: logic/eps_delay.sv */
`timescale 1ns/100ps
`default_nettype none

// Delays the activating edge of a PWM level by a count of instruction
// cycles; the deactivating edge passes at once.
module eps_delay
	import eps_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic lvl,
	input wire logic instr_tick,
	input wire logic [6:0] delay_count,
	output logic dly_out
);

	eps_dly_reg_type r;
	eps_dly_reg_type n;

	// Next state of the delay line.
	always_comb
	begin
		n = r;
		case (r.state)
			EPS_DLY_IDLE:
			begin
				n.out = 1'b0;
				if (lvl && delay_count == 7'h00)
				begin
					n.state = EPS_DLY_ON;
					n.out = 1'b1;
				end
				else if (lvl)
				begin
					n.state = EPS_DLY_WAIT;
					n.cnt = delay_count;
				end
			end
			EPS_DLY_WAIT:
			begin
				if (!lvl)
				begin
					n.state = EPS_DLY_IDLE;
				end
				else if (instr_tick && r.cnt == 7'h01)
				begin
					n.state = EPS_DLY_ON;
					n.out = 1'b1;
				end
				else if (instr_tick)
				begin
					n.cnt = r.cnt - 7'h01;
				end
			end
			EPS_DLY_ON:
			begin
				if (!lvl)
				begin
					n.state = EPS_DLY_IDLE;
					n.out = 1'b0;
				end
			end
			default:
			begin
				n.state = EPS_DLY_IDLE;
				n.out = 1'b0;
			end
		endcase
	end

	// State register.
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			r <= '{state: EPS_DLY_IDLE, default: '0};
		end
		else
		begin
			r <= n;
		end
	end

	assign dly_out = r.out;

endmodule

`default_nettype wire

/* File: logic/eps_top.sv */
// Operation
// - Each channel's select field picks period timer one, two or three; 11 reserved.
// - Select register holds channel four to one in bits 7-6 down to 1-0.
// - Shutdown flag reads 1 while outputs are forced to shutdown state.
// - Source 000 off, 001 comparator one, 010 comparator two, 011 either.
// - Sources 100 to 111 add a low interrupt pin, ORed with comparators.
// - During shutdown A and C go low, high or float per their field.
// - During shutdown B and D go low, high or float per their field.
// - With restart enabled the flag clears itself once the trigger is gone.
// - Delay count sets instruction cycles between scheduled and actual activation.
// - Sync bit set: steering updates at next period; clear: at instruction boundary.
// - Each steering enable routes the polarised PWM to its pin, else releases it.
// - Steering applies only in PWM mode with single output configuration.
// - The upper three steering bits read as zero.
// - A synced comparator's shutdown waits for the first general timer resync.
// - Low mode bits set polarity of A/C and B/D pairs.
// - Half-bridge drives A and B complementary with delayed activation.
//
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module eps_top
	import eps_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic pwm_raw,
	input wire logic [2:0] tmr_period,
	input wire logic tmr1_tick,
	input wire logic cmp1_pin,
	input wire logic cmp2_pin,
	input wire logic int_pin,
	output logic [3:0] ch_period_tick,
	output eps_pin_type out_a,
	output eps_pin_type out_b,
	output eps_pin_type out_c,
	output eps_pin_type out_d
);

`include "eps_defines.svh"

	localparam eps_top_reg_type RST_VAL = '{
		timebase: `EPS_RST_TIMEBASE,
		steer_req: 4'(`EPS_RST_STEER),
		steer_act: 4'(`EPS_RST_STEER),
		hreadyout: 1'b1,
		cfg: EPS_CFG_SINGLE,
		default: '0
	};

	eps_top_reg_type r;
	eps_top_reg_type n;
	logic [1:0] dly;
	logic instr_tick;

	// Picks one timer's period strobe by a two-bit select; 11 picks none.
	function automatic logic tb_pick(input logic [1:0] sel, input logic [2:0] tmr);
		logic v;
		v = 1'b0;
		case (sel)
			2'h0: v = tmr[0];
			2'h1: v = tmr[1];
			2'h2: v = tmr[2];
			default: v = 1'b0;
		endcase
		return v;
	endfunction

	// Shutdown state of one pin pair: bit 1 floats, else bit 0 is driven.
	function automatic eps_pin_type shut_pin(input logic [1:0] st);
		eps_pin_type p;
		p.o = st[0] & ~st[1];
		p.oe = ~st[1];
		return p;
	endfunction

	// Register read view; unmapped offsets read as zero.
	function automatic logic [31:0] rd_view(input logic ok, input logic [7:0] a,
		input eps_top_reg_type s);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (ok)
		begin
			case (a)
				`EPS_OFF_TIMEBASE: v[7:0] = s.timebase;
				`EPS_OFF_SHUTDOWN: v[7:0] = {s.ase, s.src, s.ac, s.bd};
				`EPS_OFF_RESTART: v[7:0] = {s.rsen, s.dc};
				`EPS_OFF_STEER: v[7:0] = {3'h0, s.sync, s.steer_req};
				`EPS_OFF_CHCTRL: v[7:0] = {s.cfg, s.csync, s.mode};
				default: v = 32'h0000_0000;
			endcase
		end
		return v;
	endfunction

	// One activation delay line for the A side and one for the B side.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_dly
			eps_delay u_dly (
				.core_clk(core_clk),
				.sys_rst(sys_rst),
				.lvl(gi == 0 ? pwm_raw : ~pwm_raw),
				.instr_tick(instr_tick),
				.delay_count(r.dc),
				.dly_out(dly[gi])
			);
		end
	endgenerate

	// Instruction cycle boundary, every fourth clock.
	assign instr_tick = (r.tick_cnt == `EPS_INSTR_LAST);

	// Next state of the whole block.
	always_comb
	begin
		logic [1:0] cmp_eff;
		logic int_low;
		logic trig;
		logic pwm_on;
		logic [3:0] act;
		logic [3:0] lvl;
		logic [3:0] inv;
		logic ch1_period;
		n = r;
		cmp_eff = 2'h0;
		int_low = 1'b0;
		trig = 1'b0;
		pwm_on = 1'b0;
		act = 4'h0;
		lvl = 4'h0;
		inv = 4'h0;
		ch1_period = 1'b0;

		// Two-stage synchronisers for comparator and interrupt pins.
		n.in_meta = {int_pin, cmp2_pin, cmp1_pin};
		n.in_sync = r.in_meta;

		// Timer one resynchronises comparators whose sync option is on.
		if (tmr1_tick)
		begin
			n.cmp_held = r.in_sync[1:0];
		end
		cmp_eff[0] = r.csync[0] ? r.cmp_held[0] : r.in_sync[0];
		cmp_eff[1] = r.csync[1] ? r.cmp_held[1] : r.in_sync[1];
		int_low = ~r.in_sync[2];

		// Source select: bit 0 comparator one, bit 1 comparator two, bit 2 pin.
		trig = (r.src[0] & cmp_eff[0]) | (r.src[1] & cmp_eff[1]);
		trig = trig | (r.src[2] & int_low);

		n.tick_cnt = r.tick_cnt + 2'h1;

		// Bus data phase: a write lands in the addressed register.
		if (r.wr_pend && r.addr_ok)
		begin
			case (r.addr)
				`EPS_OFF_TIMEBASE: n.timebase = hwdata[7:0];
				`EPS_OFF_SHUTDOWN:
				begin
					n.ase = hwdata[`EPS_SD_FLAG];
					n.src = hwdata[`EPS_SD_SRC_HI:`EPS_SD_SRC_LO];
					n.ac = hwdata[`EPS_SD_AC_HI:`EPS_SD_AC_LO];
					n.bd = hwdata[`EPS_SD_BD_HI:`EPS_SD_BD_LO];
				end
				`EPS_OFF_RESTART:
				begin
					n.rsen = hwdata[`EPS_RS_EN];
					n.dc = hwdata[`EPS_RS_DC_HI:`EPS_RS_DC_LO];
				end
				`EPS_OFF_STEER:
				begin
					n.sync = hwdata[`EPS_ST_SYNC];
					n.steer_req = hwdata[`EPS_ST_EN_HI:`EPS_ST_EN_LO];
				end
				`EPS_OFF_CHCTRL:
				begin
					n.cfg = eps_config_type'(hwdata[`EPS_CC_CFG_HI:`EPS_CC_CFG_LO]);
					n.csync = hwdata[`EPS_CC_CSYNC_HI:`EPS_CC_CSYNC_LO];
					n.mode = hwdata[`EPS_CC_MODE_HI:`EPS_CC_MODE_LO];
				end
				default:
				begin
					n.timebase = n.timebase;
				end
			endcase
		end

		// A live trigger sets the flag and wins over any clear.
		if (trig)
		begin
			n.ase = 1'b1;
		end
		else if (r.rsen && r.ase)
		begin
			n.ase = 1'b0;
		end

		// Period strobe of each channel's chosen time base.
		for (int k = 0; k < 4; k++)
		begin
			n.period_tick[k] = tb_pick(r.timebase[2 * k +: 2], tmr_period);
		end
		ch1_period = tb_pick(r.timebase[1:0], tmr_period);

		// Steering changes take effect at a period start or instruction boundary.
		if (r.sync ? ch1_period : instr_tick)
		begin
			n.steer_act = r.steer_req;
		end

		// Pin activity and level before polarity, per output configuration.
		pwm_on = (r.mode[3:2] == `EPS_MODE_PWM);
		case (r.cfg)
			EPS_CFG_SINGLE:
			begin
				act = r.steer_act;
				lvl = {4{pwm_raw}};
			end
			EPS_CFG_FWD:
			begin
				act = 4'hF;
				lvl = {pwm_raw, 1'b0, 1'b0, 1'b1};
			end
			EPS_CFG_HALF:
			begin
				act = 4'h3;
				lvl = {1'b0, 1'b0, dly[1], dly[0]};
			end
			EPS_CFG_REV:
			begin
				act = 4'hF;
				lvl = {1'b0, 1'b1, pwm_raw, 1'b0};
			end
			default:
			begin
				act = 4'h0;
				lvl = 4'h0;
			end
		endcase

		// Polarity: mode bit 1 inverts A and C, mode bit 0 inverts B and D.
		inv = {r.mode[0], r.mode[1], r.mode[0], r.mode[1]};

		// Drive the pins; shutdown overrides everything else.
		for (int k = 0; k < 4; k++)
		begin
			if (n.ase)
			begin
				n.pins[k] = shut_pin(k[0] ? r.bd : r.ac);
			end
			else if (pwm_on && act[k])
			begin
				n.pins[k].o = lvl[k] ^ inv[k];
				n.pins[k].oe = 1'b1;
			end
			else
			begin
				n.pins[k].o = 1'b0;
				n.pins[k].oe = 1'b0;
			end
		end

		// Bus address phase; read data come from the updated registers.
		n.wr_pend = hsel && htrans[1] && hready && hwrite;
		if (hsel && htrans[1] && hready)
		begin
			n.addr = haddr[7:0];
			n.addr_ok = (haddr[31:8] == 24'h00_0000) && (hsize == 3'h2);
			if (!hwrite)
			begin
				n.hrdata = rd_view(n.addr_ok, n.addr, n);
			end
		end
		n.hreadyout = 1'b1;
		n.hresp = 1'b0;
	end

	// State register.
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			r <= RST_VAL;
		end
		else
		begin
			r <= n;
		end
	end

	assign hrdata = r.hrdata;
	assign hreadyout = r.hreadyout;
	assign hresp = r.hresp;
	assign ch_period_tick = r.period_tick;
	assign out_a = r.pins[0];
	assign out_b = r.pins[1];
	assign out_c = r.pins[2];
	assign out_d = r.pins[3];

endmodule

`default_nettype wire

/* File: tb/eps_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
`include "eps_defines.svh"

module eps_monitor
	import eps_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic pwm_raw,
	input wire logic [2:0] tmr_period,
	input wire logic cmp1_pin,
	input wire logic cmp2_pin,
	input wire logic int_pin,
	input wire logic [3:0] ch_period_tick,
	input wire eps_pin_type out_a,
	input wire eps_pin_type out_b,
	input wire eps_pin_type out_c,
	input wire eps_pin_type out_d
);
	logic dw_r;
	logic [7:0] da_r, tb_r, sd_r, st_r, cc_r;
	logic ac_ok, bd_ok, nosd, steer_on;
	logic [3:0] sel_t;

	default clocking @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	// Mirrors register writes so the properties know the programmed fields.
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			dw_r <= 1'h0;
			da_r <= 8'h00;
			tb_r <= `EPS_RST_TIMEBASE;
			sd_r <= `EPS_RST_SHUTDOWN;
			st_r <= `EPS_RST_STEER;
			cc_r <= `EPS_RST_CHCTRL;
		end
		else
		begin
			if (hreadyout) dw_r <= hsel && htrans[1] && hwrite && hready && hsize == 3'h2
				&& haddr[31:8] == 24'h0;
			if (hreadyout) da_r <= haddr[7:0];
			if (dw_r && da_r == `EPS_OFF_TIMEBASE) tb_r <= hwdata[7:0];
			if (dw_r && da_r == `EPS_OFF_SHUTDOWN) sd_r <= hwdata[7:0];
			if (dw_r && da_r == `EPS_OFF_STEER) st_r <= hwdata[7:0];
			if (dw_r && da_r == `EPS_OFF_CHCTRL) cc_r <= hwdata[7:0];
		end
	end

	// Expected shutdown drive of each pin pair, and the routed timer strobes.
	assign ac_ok = out_a.oe == !sd_r[3] && out_c.oe == !sd_r[3]
		&& (sd_r[3] || (out_a.o == sd_r[2] && out_c.o == sd_r[2]));
	assign bd_ok = out_b.oe == !sd_r[1] && out_d.oe == !sd_r[1]
		&& (sd_r[1] || (out_b.o == sd_r[0] && out_d.o == sd_r[0]));
	assign nosd = sd_r[7:4] == 4'h0;
	assign steer_on = nosd && cc_r[3:2] == `EPS_MODE_PWM && cc_r[7:6] == 2'h0 && !st_r[4];
	assign sel_t = {tmr_period[tb_r[7:6]], tmr_period[tb_r[5:4]],
		tmr_period[tb_r[3:2]], tmr_period[tb_r[1:0]]};

	a_int_sd_ac: assert property ((sd_r[6] && !int_pin)[*3] |-> ##1 ac_ok)
		else $error("Low interrupt pin did not force A and C state.");
	a_int_sd_bd: assert property ((sd_r[6] && !int_pin)[*3] |-> ##1 bd_ok)
		else $error("Low interrupt pin did not force B and D state.");
	a_cmp1_sd: assert property ((sd_r[4] && !cc_r[4] && cmp1_pin)[*3] |-> ##1 ac_ok && bd_ok)
		else $error("Comparator one did not force shutdown.");
	a_cmp2_sd: assert property ((sd_r[5] && !cc_r[5] && cmp2_pin)[*3] |-> ##1 ac_ok && bd_ok)
		else $error("Comparator two did not force shutdown.");
	a_steer_a_pol: assert property ((steer_on && st_r[0])[*6] |->
		out_a.oe && out_a.o == ($past(pwm_raw) ^ $past(cc_r[1])))
		else $error("Steered A pin has wrong drive or polarity.");
	a_steer_b_off: assert property ((steer_on && !st_r[1])[*6] |-> !out_b.oe)
		else $error("Unsteered B pin is still driven.");
	a_idle_rel: assert property ((nosd && cc_r[3:2] != 2'h3)[*2] |->
		!(out_a.oe || out_b.oe || out_c.oe || out_d.oe))
		else $error("Pins driven outside PWM mode.");
	a_tick_ch1: assert property (tb_r[1:0] != 2'h3 && !$past(sys_rst) |=>
		ch_period_tick[0] == $past(sel_t[0]))
		else $error("Channel one period strobe from wrong timer.");
	a_tick_ch4: assert property (tb_r[7:6] != 2'h3 && !$past(sys_rst) |=>
		ch_period_tick[3] == $past(sel_t[3]))
		else $error("Channel four period strobe from wrong timer.");
endmodule

bind eps_top eps_monitor i_eps_monitor (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .pwm_raw(pwm_raw), .tmr_period(tmr_period),
	.cmp1_pin(cmp1_pin), .cmp2_pin(cmp2_pin), .int_pin(int_pin),
	.ch_period_tick(ch_period_tick), .out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d));

`default_nettype wire

/* File: tb/eps_bridge.sv */
`timescale 1ns/100ps
`default_nettype none

module eps_bridge
	import eps_pkg::*;
(
	input wire eps_pin_type out_a,
	input wire eps_pin_type out_b,
	input wire eps_pin_type out_c,
	input wire eps_pin_type out_d,
	output logic [3:0] gate_lvl
);
	// A released gate input is held low by the bridge pull-down, so a half leg never floats on.
	assign gate_lvl = {out_d.oe & out_d.o, out_c.oe & out_c.o,
		out_b.oe & out_b.o, out_a.oe & out_a.o};
endmodule

`default_nettype wire

/* File: tb/eps_top_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "eps_defines.svh"

module eps_top_tb_top
	import eps_pkg::*;
;
	logic core_clk = 1'h0, sys_rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, pwm_raw = 1'h0;
	logic tmr1_tick = 1'h0, cmp1_pin = 1'h0, cmp2_pin = 1'h0, int_pin = 1'h1, rd_dp = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0, ac, bd;
	logic [2:0] hsize = 3'h2, tmr_period = 3'h0;
	logic hreadyout, hresp;
	logic [3:0] ch_period_tick, gate_lvl;
	logic [7:0] v;
	logic [39:0] cur;
	logic [39:0] exp_q[$];
	eps_pin_type out_a, out_b, out_c, out_d;
	int miscompares = 0, checks_done = 0, seed = 13053, n;
	bit rnd_on = 1'h0;

	eps_top i_eps_top (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pwm_raw(pwm_raw),
		.tmr_period(tmr_period), .tmr1_tick(tmr1_tick), .cmp1_pin(cmp1_pin), .cmp2_pin(cmp2_pin),
		.int_pin(int_pin), .ch_period_tick(ch_period_tick), .out_a(out_a), .out_b(out_b),
		.out_c(out_c), .out_d(out_d));
	eps_bridge i_eps_bridge (.out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d),
		.gate_lvl(gate_lvl));

	// Free-running clock of 25 ns.
	always #12.5 core_clk = ~core_clk;

	task automatic wrap_up;
		// Reads whose data phase was never compared count as one mismatch in all.
		if (exp_q.size() != 0) miscompares++;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask

	// Code 1x expects a released pin, otherwise a driven pin at level code[0].
	task automatic chk_pin(input string nm, input eps_pin_type p, input logic [1:0] c);
		chk(nm, {30'h0, p.oe, p.oe & p.o}, {30'h0, !c[1], !c[1] & c[0]});
	endtask

	task automatic wait_rdy;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (hreadyout !== 1'h1 && n < 64);
		if (n >= 64)
		begin
			miscompares++;
			wrap_up();
		end
	endtask

	// One single word transfer; for a read, d is the expected value noted for the watcher.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		if (!wr) exp_q.push_back({a, 24'h0, d});
		wait_rdy();
	endtask

	// Compares each read data phase with the oldest noted value.
	always @(posedge core_clk)
	begin
		if (rd_dp && hreadyout && exp_q.size() > 0)
		begin
			cur = exp_q.pop_front();
			chk($sformatf("reg %h", cur[39:32]), hrdata, cur[31:0]);
		end
		if (hreadyout) rd_dp <= hsel && htrans[1] && !hwrite;
	end

	// Random timer strobes and PWM levels while the tick routing is exercised.
	always @(posedge core_clk)
		if (rnd_on)
		begin
			tmr_period <= 3'($random(seed));
			pwm_raw <= 1'($random(seed));
			tmr1_tick <= 1'($random(seed));
		end

	// Main sequence of tests.
	initial
	begin
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'h0;
		bus(1'h0, `EPS_OFF_TIMEBASE, `EPS_RST_TIMEBASE);
		bus(1'h0, `EPS_OFF_SHUTDOWN, `EPS_RST_SHUTDOWN);
		bus(1'h0, `EPS_OFF_RESTART, `EPS_RST_RESTART);
		bus(1'h0, `EPS_OFF_STEER, `EPS_RST_STEER);
		bus(1'h0, 8'h20, 8'h00);
		rnd_on = 1'h1;
		for (int k = 0; k < 3; k++)
		begin
			v = {2'((k + 1) % 3), 2'(k), 2'((k + 2) % 3), 2'(k)};
			bus(1'h1, `EPS_OFF_TIMEBASE, v);
			repeat (20) @(posedge core_clk);
			bus(1'h0, `EPS_OFF_TIMEBASE, v);
		end
		rnd_on = 1'h0;
		{tmr_period, pwm_raw, tmr1_tick} <= 5'h00;
		bus(1'h1, `EPS_OFF_STEER, 8'hFF);
		bus(1'h0, `EPS_OFF_STEER, 8'h1F);
		$display("test registers done");
		for (int s = 0; s < 8; s++)
		begin
			ac = 2'(s % 3);
			bd = 2'((s + 1) % 3);
			v = {1'h0, 3'(s), ac, bd};
			bus(1'h1, `EPS_OFF_SHUTDOWN, v);
			int_pin <= !(s == 0 || s > 3);
			cmp1_pin <= s == 0 || s == 1 || s == 3;
			cmp2_pin <= s == 0 || s == 2;
			repeat (6) @(posedge core_clk);
			bus(1'h0, `EPS_OFF_SHUTDOWN, {s != 0, v[6:0]});
			if (s != 0)
			begin
				chk_pin("out_a", out_a, ac);
				chk_pin("out_b", out_b, bd);
				chk_pin("out_d", out_d, bd);
				chk("bridge", {31'h0, gate_lvl[2]}, {31'h0, !ac[1] & ac[0]});
			end
			{cmp1_pin, cmp2_pin, int_pin} <= 3'h1;
			repeat (6) @(posedge core_clk);
			bus(1'h0, `EPS_OFF_SHUTDOWN, {s != 0, v[6:0]});
			bus(1'h1, `EPS_OFF_SHUTDOWN, v);
			bus(1'h0, `EPS_OFF_SHUTDOWN, v);
		end
		bus(1'h1, `EPS_OFF_RESTART, 8'h80);
		bus(1'h1, `EPS_OFF_SHUTDOWN, 8'h10);
		cmp1_pin <= 1'h1;
		repeat (6) @(posedge core_clk);
		bus(1'h0, `EPS_OFF_SHUTDOWN, 8'h90);
		cmp1_pin <= 1'h0;
		repeat (6) @(posedge core_clk);
		bus(1'h0, `EPS_OFF_SHUTDOWN, 8'h10);
		// Comparator one resynchronised: no shutdown until the timer one strobe.
		bus(1'h1, `EPS_OFF_CHCTRL, 8'h10);
		cmp1_pin <= 1'h1;
		repeat (6) @(posedge core_clk);
		bus(1'h0, `EPS_OFF_SHUTDOWN, 8'h10);
		tmr1_tick <= 1'h1;
		@(posedge core_clk);
		tmr1_tick <= 1'h0;
		repeat (3) @(posedge core_clk);
		bus(1'h0, `EPS_OFF_SHUTDOWN, 8'h90);
		cmp1_pin <= 1'h0;
		bus(1'h1, `EPS_OFF_SHUTDOWN, 8'h00);
		$display("test shutdown done");
		pwm_raw <= 1'h1;
		for (int m = 11; m < 16; m++)
		begin
			bus(1'h1, `EPS_OFF_CHCTRL, 8'(m));
			bus(1'h1, `EPS_OFF_STEER, 8'h05);
			repeat (8) @(posedge core_clk);
			chk_pin("out_a", out_a, m > 11 ? {1'h0, !m[1]} : 2'h2);
			chk_pin("out_c", out_c, m > 11 ? {1'h0, !m[1]} : 2'h2);
			chk_pin("out_b", out_b, 2'h2);
		end
		bus(1'h1, `EPS_OFF_TIMEBASE, 8'h00);
		bus(1'h1, `EPS_OFF_STEER, 8'h1A);
		repeat (8) @(posedge core_clk);
		chk_pin("out_a", out_a, 2'h0);
		tmr_period <= 3'h1;
		@(posedge core_clk);
		tmr_period <= 3'h0;
		repeat (4) @(posedge core_clk);
		chk_pin("out_a", out_a, 2'h2);
		chk_pin("out_b", out_b, 2'h0);
		$display("test steering done");
		bus(1'h1, `EPS_OFF_CHCTRL, 8'h8C);
		bus(1'h1, `EPS_OFF_RESTART, 8'h05);
		pwm_raw <= 1'h0;
		repeat (10) @(posedge core_clk);
		pwm_raw <= 1'h1;
		n = 0;
		while (out_a.o !== 1'h1 && n < 40)
		begin
			@(posedge core_clk);
			n++;
		end
		// Five instruction cycles on tick boundaries, then the pin flop and our sample.
		chk("delay", {31'h0, n >= 20 && n <= 23}, 32'h1);
		chk_pin("out_b", out_b, 2'h0);
		$display("test delay done");
		wrap_up();
	end
endmodule

`default_nettype wire
